// File: core/capcomp_pkg.sv
package capcomp_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int FLAG_W = 16;
   localparam int SEL_W = 2;
   localparam int LINE_N = 4;
   localparam int GROUP_N = 7;
   localparam int ROUTE_W = 14;

   // Register byte addresses
   localparam logic [11:0] OFS_FLAG_WORD = 12'h10C;
   localparam logic [11:0] OFS_FLAG_SET = 12'h110;
   localparam logic [11:0] OFS_FLAG_CLEAR = 12'h114;
   localparam logic [11:0] OFS_ROUTING = 12'h118;
   localparam logic [11:0] OFS_ENABLE = 12'h11C;

   localparam logic [15:0] RST_FLAG_WORD = 16'h0000;
   localparam logic [13:0] RST_ROUTING = 14'h3940;
   localparam logic [15:0] RST_ENABLE = 16'h0000;

   // Event flag word, set port and enable register bit positions
   localparam int BIT_CH0_RISE = 0;
   localparam int BIT_TRAP_FLAG = 10;
   localparam int BIT_TRAP_STATE = 11;
   localparam int BIT_SOFT_HALL = 11;
   localparam int BIT_HALL_MISMATCH = 13;
   localparam int BIT_HALT_STATE = 14;
   localparam int BIT_HALT_ENABLE = 14;

   // Set port bits that set a flag directly
   localparam logic [15:0] SET_MASK = 16'hF7FF;
   // Clear port bits that clear a flag
   localparam logic [15:0] CLEAR_MASK = 16'hF7FF;
   // Flags from the timer datapath; trap state follows the trap flag
   localparam logic [15:0] HW_MASK = 16'hF7FF;
   // Writable enable bits; bit 11 reserved
   localparam logic [15:0] ENABLE_MASK = 16'hF7FF;
   // Events that may reach a service line
   localparam logic [15:0] IRQ_MASK = 16'hB7FF;

   // Two events per group, selector at bits 2g+1:2g
   localparam int GRP_A [GROUP_N] = '{0, 2, 4, 12, 10, 6, 8};
   localparam int GRP_B [GROUP_N] = '{1, 3, 5, 15, 13, 7, 9};
endpackage

// File: core/event_flags_if.sv
`timescale 1ns/10ps
interface event_flags_if;
   logic ce;
   logic [15:0] setReq;
   logic [15:0] clrReq;
   logic [15:0] flags;
   modport store (input ce, input setReq, input clrReq, output flags);
   modport owner (output ce, output setReq, output clrReq, input flags);
endinterface

// File: core/event_flag_store.sv
`timescale 1ns/10ps
module event_flag_store (
   input wire logic sys_clk,
   input wire logic rst,
   event_flags_if.store bus
);
   logic [15:0] flags_q;
   logic [15:0] flags_d;

   // Set dominates clear so a coincident event survives
   assign flags_d = (flags_q & ~bus.clrReq) | bus.setReq;
   assign bus.flags = flags_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flags_q <= capcomp_pkg::RST_FLAG_WORD;
      end else if (bus.ce) begin
         flags_q <= flags_d;
      end
   end
endmodule

// File: core/line_router.sv
`timescale 1ns/10ps
module line_router (
   input wire logic [1:0] sel,
   input wire logic [1:0] events,
   output logic [3:0] lines
);
   logic anyEvent;
   logic [3:0] decoded;

   assign anyEvent = |events;
   assign decoded = 4'h1 << sel;
   assign lines = anyEvent ? decoded : 4'h0;
endmodule

// File: core/capcomp_event_flag_routing.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
// Contract
// - Set bits 0-5 raise channel flags
// - Set bits 6-9 raise timer flags
// - Set bit 10 raises trap flag and state
// - Set bit 11 fires software hall compare
// - Set bits 12-15 raise hall/halt/copy flags
// - Zero bits change nothing
// - Clear bits 0-9, 12-15 clear flags
// - Trap clear ignored while trap input low
// - Set/clear ports and reserved bits read zero
// - Channel 0 selector picks line 0-3
// - Channel 1, 2 selectors route likewise
// - Hall selector routes match and copy
// - Fault selector routes trap and mismatch
// - Main timer selector routes its events
// - Aux timer selector routes its events
// - Line fires on enabled set condition
// - Disabled events never request service
// - Mismatch sets halt when halt enabled
module capcomp_event_flag_routing (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [11:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [31:0] rdData,
   input wire logic [15:0] hwSet,
   input wire logic trapInN,
   input wire logic trapStateClr,
   output logic softHallCompare,
   output logic serviceLine0,
   output logic serviceLine1,
   output logic serviceLine2,
   output logic serviceLine3
);
   event_flags_if flagBus ();

   logic [31:0] rdData_q;
   logic [31:0] rdData_d;
   logic [13:0] routing_q;
   logic [15:0] enable_q;
   logic softHall_q;
   logic [3:0] lines_q;
   logic [3:0] lines_d;

   logic hitFlagWord;
   logic hitSet;
   logic hitClear;
   logic hitRouting;
   logic hitEnable;
   logic wrSet;
   logic wrClear;
   logic wrRouting;
   logic wrEnable;
   logic [15:0] wrLow;
   logic [15:0] swSet;
   logic [15:0] swClear;
   logic [15:0] baseSet;
   logic [15:0] setCond;
   logic [15:0] clrCond;
   logic [15:0] flags;
   logic [15:0] irqEvents;
   logic haltEnable;
   logic trapClearAllowed;
   logic [3:0] groupLines [capcomp_pkg::GROUP_N];

   // Address decode
   assign hitFlagWord = addr == capcomp_pkg::OFS_FLAG_WORD;
   assign hitSet = addr == capcomp_pkg::OFS_FLAG_SET;
   assign hitClear = addr == capcomp_pkg::OFS_FLAG_CLEAR;
   assign hitRouting = addr == capcomp_pkg::OFS_ROUTING;
   assign hitEnable = addr == capcomp_pkg::OFS_ENABLE;
   assign wrSet = wrStb & hitSet;
   assign wrClear = wrStb & hitClear;
   assign wrRouting = wrStb & hitRouting;
   assign wrEnable = wrStb & hitEnable;
   assign wrLow = wrData[15:0];

   // Only ones act; zeros leave flags alone
   assign swSet = wrSet ? (wrLow & capcomp_pkg::SET_MASK) : 16'h0000;
   assign swClear = wrClear ? (wrLow & capcomp_pkg::CLEAR_MASK) : 16'h0000;

   assign haltEnable = enable_q[capcomp_pkg::BIT_HALT_ENABLE];
   // Trap pin still active keeps the trap flag pinned
   assign trapClearAllowed = trapInN;

   assign baseSet = swSet | (hwSet & capcomp_pkg::HW_MASK);

   always_comb begin
      setCond = baseSet;
      // Trap flag set also enters trap state
      setCond[capcomp_pkg::BIT_TRAP_STATE] = baseSet[capcomp_pkg::BIT_TRAP_FLAG];
      // Automatic halt follows a hall mismatch
      setCond[capcomp_pkg::BIT_HALT_STATE] = baseSet[capcomp_pkg::BIT_HALT_STATE]
         | (baseSet[capcomp_pkg::BIT_HALL_MISMATCH] & haltEnable);
   end

   always_comb begin
      clrCond = swClear;
      clrCond[capcomp_pkg::BIT_TRAP_FLAG] = swClear[capcomp_pkg::BIT_TRAP_FLAG]
         & trapClearAllowed;
      // Trap state only leaves once the trap flag is gone
      clrCond[capcomp_pkg::BIT_TRAP_STATE] = trapStateClr
         & ~flags[capcomp_pkg::BIT_TRAP_FLAG];
   end

   assign flagBus.ce = ce;
   assign flagBus.setReq = setCond;
   assign flagBus.clrReq = clrCond;
   assign flags = flagBus.flags;

   // Set wins inside the store
   event_flag_store flagStore (
      .sys_clk(sys_clk),
      .rst(rst),
      .bus(flagBus)
   );

   // Requests come from set conditions, not from standing flags
   assign irqEvents = setCond & enable_q & capcomp_pkg::IRQ_MASK;

   genvar g;
   generate
      for (g = 0; g < capcomp_pkg::GROUP_N; g++) begin : gRoute
         line_router router (
            .sel(routing_q[2 * g + 1 -: 2]),
            .events({irqEvents[capcomp_pkg::GRP_B[g]], irqEvents[capcomp_pkg::GRP_A[g]]}),
            .lines(groupLines[g])
         );
      end
   endgenerate

   always_comb begin
      lines_d = 4'h0;
      for (int i = 0; i < capcomp_pkg::GROUP_N; i++) begin
         lines_d = lines_d | groupLines[i];
      end
   end

   // Read mux; write-only ports and reserved bits give zero
   always_comb begin
      rdData_d = 32'h0000_0000;
      if (hitFlagWord) begin
         rdData_d[15:0] = flags;
      end else if (hitRouting) begin
         rdData_d[13:0] = routing_q;
      end else if (hitEnable) begin
         rdData_d[15:0] = enable_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         routing_q <= capcomp_pkg::RST_ROUTING;
         enable_q <= capcomp_pkg::RST_ENABLE;
      end else if (ce) begin
         if (wrRouting) begin
            routing_q <= wrData[13:0];
         end
         if (wrEnable) begin
            enable_q <= wrLow & capcomp_pkg::ENABLE_MASK;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData_q <= 32'h0000_0000;
      end else if (ce) begin
         rdData_q <= rdStb ? rdData_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         softHall_q <= 1'b0;
         lines_q <= 4'h0;
      end else if (ce) begin
         // Hall compare pulse, no flag touched here
         softHall_q <= wrSet & wrLow[capcomp_pkg::BIT_SOFT_HALL];
         lines_q <= lines_d;
      end
   end

   assign rdData = rdData_q;
   assign softHallCompare = softHall_q;
   assign serviceLine0 = lines_q[0];
   assign serviceLine1 = lines_q[1];
   assign serviceLine2 = lines_q[2];
   assign serviceLine3 = lines_q[3];

   // Checks
   property p_chan_set;
      @(posedge sys_clk) disable iff (rst)
      (ce && wrSet && wrLow[capcomp_pkg::BIT_CH0_RISE])
      |=> flags[capcomp_pkg::BIT_CH0_RISE];
   endproperty
   a_chan_set: assert property (p_chan_set) else $error("channel flag not set");

   property p_timer_set;
      @(posedge sys_clk) disable iff (rst)
      (ce && wrSet && wrLow[9:6] == 4'hF) |=> (flags[9:6] == 4'hF);
   endproperty
   a_timer_set: assert property (p_timer_set) else $error("timer flags not set");

   property p_trap_set;
      @(posedge sys_clk) disable iff (rst)
      (ce && wrSet && wrLow[capcomp_pkg::BIT_TRAP_FLAG])
      |=> (flags[capcomp_pkg::BIT_TRAP_FLAG] && flags[capcomp_pkg::BIT_TRAP_STATE]);
   endproperty
   a_trap_set: assert property (p_trap_set) else $error("trap flag or state missing");

   property p_soft_hall;
      @(posedge sys_clk) disable iff (rst)
      ce |=> (softHallCompare == $past(wrSet && wrLow[capcomp_pkg::BIT_SOFT_HALL]));
   endproperty
   a_soft_hall: assert property (p_soft_hall) else $error("hall compare pulse wrong");

   property p_halt_copy_set;
      @(posedge sys_clk) disable iff (rst)
      (ce && wrSet && wrLow[15:12] == 4'hF) |=> (flags[15:12] == 4'hF);
   endproperty
   a_halt_copy_set: assert property (p_halt_copy_set) else $error("hall group not set");

   property p_clear;
      @(posedge sys_clk) disable iff (rst)
      (ce && wrClear && wrLow[0] && !setCond[0]) |=> !flags[0];
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");

   property p_trap_hold;
      @(posedge sys_clk) disable iff (rst)
      (ce && !trapInN && flags[capcomp_pkg::BIT_TRAP_FLAG])
      |=> flags[capcomp_pkg::BIT_TRAP_FLAG];
   endproperty
   a_trap_hold: assert property (p_trap_hold) else $error("trap flag cleared under pin");

   property p_port_read_zero;
      @(posedge sys_clk) disable iff (rst)
      (ce && rdStb && (hitSet || hitClear)) |=> (rdData == 32'h0000_0000);
   endproperty
   a_port_read_zero: assert property (p_port_read_zero) else $error("port read not zero");

   property p_reserved_clear;
      @(posedge sys_clk) disable iff (rst)
      (ce && wrClear && !trapStateClr && flags[capcomp_pkg::BIT_TRAP_STATE])
      |=> flags[capcomp_pkg::BIT_TRAP_STATE];
   endproperty
   a_reserved_clear: assert property (p_reserved_clear) else $error("bit 11 cleared");

   property p_route_ch0;
      @(posedge sys_clk) disable iff (rst)
      (ce && irqEvents[0] && routing_q[1:0] == 2'h2) |=> serviceLine2;
   endproperty
   a_route_ch0: assert property (p_route_ch0) else $error("channel 0 misrouted");

   property p_no_request;
      @(posedge sys_clk) disable iff (rst)
      (ce && (setCond & enable_q & capcomp_pkg::IRQ_MASK) == 16'h0000)
      |=> (lines_q == 4'h0);
   endproperty
   a_no_request: assert property (p_no_request) else $error("line without enabled event");

   property p_auto_halt;
      @(posedge sys_clk) disable iff (rst)
      (ce && baseSet[capcomp_pkg::BIT_HALL_MISMATCH] && haltEnable)
      |=> flags[capcomp_pkg::BIT_HALT_STATE];
   endproperty
   a_auto_halt: assert property (p_auto_halt) else $error("halt not set on mismatch");

   property p_set_wins;
      @(posedge sys_clk) disable iff (rst)
      (ce && hwSet[7] && wrClear && wrLow[7]) |=> flags[7];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat set");

   property p_zero_keeps;
      @(posedge sys_clk) disable iff (rst)
      (ce && (wrSet || wrClear) && wrLow == 16'h0000 && hwSet == 16'h0000 && !trapStateClr)
      |=> $stable(flags);
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed flags");

   property p_reserved_read;
      @(posedge sys_clk) disable iff (rst)
      (ce && rdStb && hitRouting) |=> (rdData[31:14] == 18'h00000);
   endproperty
   a_reserved_read: assert property (p_reserved_read) else $error("reserved bits set");

   property p_route_ch1;
      @(posedge sys_clk) disable iff (rst)
      (ce && (irqEvents[2] || irqEvents[3])) |=> lines_q[$past(routing_q[3:2])];
   endproperty
   a_route_ch1: assert property (p_route_ch1) else $error("channel 1 misrouted");

   property p_route_ch2;
      @(posedge sys_clk) disable iff (rst)
      (ce && (irqEvents[4] || irqEvents[5])) |=> lines_q[$past(routing_q[5:4])];
   endproperty
   a_route_ch2: assert property (p_route_ch2) else $error("channel 2 misrouted");

   property p_route_hall;
      @(posedge sys_clk) disable iff (rst)
      (ce && (irqEvents[12] || irqEvents[15])) |=> lines_q[$past(routing_q[7:6])];
   endproperty
   a_route_hall: assert property (p_route_hall) else $error("hall event misrouted");

   property p_route_fault;
      @(posedge sys_clk) disable iff (rst)
      (ce && (irqEvents[10] || irqEvents[13])) |=> lines_q[$past(routing_q[9:8])];
   endproperty
   a_route_fault: assert property (p_route_fault) else $error("fault event misrouted");

   property p_route_main;
      @(posedge sys_clk) disable iff (rst)
      (ce && (irqEvents[6] || irqEvents[7])) |=> lines_q[$past(routing_q[11:10])];
   endproperty
   a_route_main: assert property (p_route_main) else $error("main timer misrouted");

   property p_route_aux;
      @(posedge sys_clk) disable iff (rst)
      (ce && (irqEvents[8] || irqEvents[9])) |=> lines_q[$past(routing_q[13:12])];
   endproperty
   a_route_aux: assert property (p_route_aux) else $error("aux timer misrouted");

   // Standing flags alone must stay quiet
   property p_line_needs_set;
      @(posedge sys_clk) disable iff (rst)
      (ce && hwSet == 16'h0000 && !wrSet) |=> (lines_q == 4'h0);
   endproperty
   a_line_needs_set: assert property (p_line_needs_set) else $error("line without set");

   property p_single_line;
      @(posedge sys_clk) disable iff (rst)
      (ce && irqEvents == 16'h0001 && routing_q[1:0] == 2'h0) |=> (lines_q == 4'h1);
   endproperty
   a_single_line: assert property (p_single_line) else $error("extra line raised");

   c_line_fire: cover property (@(posedge sys_clk) disable iff (rst) serviceLine3);
   c_trap_held: cover property (@(posedge sys_clk) disable iff (rst)
      !trapInN && wrClear && wrLow[capcomp_pkg::BIT_TRAP_FLAG]);
   c_auto_halt: cover property (@(posedge sys_clk) disable iff (rst)
      baseSet[capcomp_pkg::BIT_HALL_MISMATCH] && haltEnable);
   c_soft_hall: cover property (@(posedge sys_clk) disable iff (rst) softHallCompare);
   c_set_wins: cover property (@(posedge sys_clk) disable iff (rst)
      hwSet[7] && wrClear && wrLow[7]);
endmodule

// File: tb/service_request_sink.sv
`timescale 1ns/10ps
module service_request_sink (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] lines,
   output logic [15:0] count [4]
);
   // One count per cycle high, as each pulse is one request
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (rst) begin
            count[i] <= 16'h0000;
         end else if (lines[i]) begin
            count[i] <= count[i] + 16'h0001;
         end
      end
   end
endmodule

// File: tb/test_capcomp_event_flag_routing.sv
`timescale 1ns/10ps
module test_capcomp_event_flag_routing;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [31:0] wrData = 32'h00000000;
   logic wrStb = 1'b0;
   logic rdStb = 1'b0;
   logic [15:0] hwSet = 16'h0000;
   logic trapInN = 1'b1;
   logic trapStateClr = 1'b0;
   logic [31:0] rdData;
   logic softHallCompare;
   logic [3:0] lines;
   logic [15:0] count [4];
   int expCount [4];
   int n_mismatch = 0;
   int n_checks = 0;
   logic [31:0] rng = 32'h0000CAED;
   logic [15:0] flags;
   logic [15:0] en;
   logic [13:0] route;
   logic ce = 1'b1;
   logic [3:0] expL;

   always #5 sys_clk = ~sys_clk;

   capcomp_event_flag_routing DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .hwSet(hwSet),
      .trapInN(trapInN), .trapStateClr(trapStateClr), .softHallCompare(softHallCompare),
      .serviceLine0(lines[0]), .serviceLine1(lines[1]), .serviceLine2(lines[2]),
      .serviceLine3(lines[3]));

   service_request_sink sink (.sys_clk(sys_clk), .rst(rst), .lines(lines), .count(count));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   function automatic logic [15:0] setFlags(input logic [15:0] f, input logic [15:0] s,
                                           input logic [15:0] e);
      logic [15:0] r;
      r = f | (s & capcomp_pkg::SET_MASK);
      if (s[10]) r[11] = 1'b1;
      if (s[13] && e[14]) r[14] = 1'b1;
      return r;
   endfunction

   function automatic logic [15:0] clrFlags(input logic [15:0] f, input logic [15:0] c,
                                           input logic trapLow);
      logic [15:0] m;
      m = c & capcomp_pkg::CLEAR_MASK;
      if (trapLow) m[10] = 1'b0;
      return f & ~m;
   endfunction

   function automatic logic [3:0] expLines(input logic [15:0] s, input logic [15:0] e,
                                          input logic [13:0] r);
      logic [15:0] a;
      logic [3:0] l;
      a = s & e & capcomp_pkg::IRQ_MASK;
      l = 4'h0;
      for (int g = 0; g < capcomp_pkg::GROUP_N; g++) begin
         if (a[capcomp_pkg::GRP_A[g]] || a[capcomp_pkg::GRP_B[g]]) l[r[2*g +: 2]] = 1'b1;
      end
      return l;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [15:0] hw);
      @(posedge sys_clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      hwSet <= hw;
      @(posedge sys_clk);
      wrStb <= 1'b0;
      hwSet <= 16'h0000;
      #1;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge sys_clk);
      rdStb <= 1'b0;
      #1;
      chk(rdData, exp);
   endtask

   task automatic setw(input logic [15:0] s);
      logic [3:0] l;
      l = expLines(s, en, route);
      wr(capcomp_pkg::OFS_FLAG_SET, {16'h0000, s}, 16'h0000);
      chk({28'h0000000, lines}, {28'h0000000, l});
      chk({31'h00000000, softHallCompare}, {31'h00000000, s[11]});
      flags = setFlags(flags, s, en);
      for (int i = 0; i < 4; i++) expCount[i] += l[i];
   endtask

   task automatic end_sim;
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #900000;
      n_mismatch++;
      end_sim;
   end

   initial begin
      flags = 16'h0000;
      en = 16'h0000;
      route = capcomp_pkg::RST_ROUTING;
      for (int i = 0; i < 4; i++) expCount[i] = 0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      rdc(capcomp_pkg::OFS_ROUTING, 32'h00003940);
      rdc(capcomp_pkg::OFS_FLAG_WORD, 32'h00000000);
      setw(16'hFFFF);
      rdc(capcomp_pkg::OFS_FLAG_WORD, {16'h0000, flags});
      rdc(capcomp_pkg::OFS_FLAG_SET, 32'h00000000);
      rdc(capcomp_pkg::OFS_FLAG_CLEAR, 32'h00000000);
      rdc(12'h120, 32'h00000000);
      wr(capcomp_pkg::OFS_FLAG_CLEAR, 32'h00000000, 16'h0000);
      rdc(capcomp_pkg::OFS_FLAG_WORD, {16'h0000, flags});
      @(posedge sys_clk);
      trapInN <= 1'b0;
      wr(capcomp_pkg::OFS_FLAG_CLEAR, 32'hFFFFFFFF, 16'h0000);
      rdc(capcomp_pkg::OFS_FLAG_WORD, 32'h00000C00);
      @(posedge sys_clk);
      trapInN <= 1'b1;
      wr(capcomp_pkg::OFS_FLAG_CLEAR, 32'h00000400, 16'h0000);
      rdc(capcomp_pkg::OFS_FLAG_WORD, 32'h00000800);
      @(posedge sys_clk);
      trapStateClr <= 1'b1;
      @(posedge sys_clk);
      trapStateClr <= 1'b0;
      // Hardware set and software clear in the same edge
      wr(capcomp_pkg::OFS_FLAG_CLEAR, 32'h00000080, 16'h0080);
      rdc(capcomp_pkg::OFS_FLAG_WORD, 32'h00000080);
      flags = 16'h0080;
      // Clock enable low swallows a write
      @(posedge sys_clk);
      ce <= 1'b0;
      wr(capcomp_pkg::OFS_FLAG_SET, 32'h00000001, 16'h0000);
      @(posedge sys_clk);
      ce <= 1'b1;
      rdc(capcomp_pkg::OFS_FLAG_WORD, {16'h0000, flags});
      en = capcomp_pkg::ENABLE_MASK;
      wr(capcomp_pkg::OFS_ENABLE, 32'hFFFFFFFF, 16'h0000);
      rdc(capcomp_pkg::OFS_ENABLE, {16'h0000, en});
      for (int g = 0; g < capcomp_pkg::GROUP_N; g++) begin
         for (int c = 0; c < 4; c++) begin
            route = 14'h0000;
            route[2*g +: 2] = c[1:0];
            wr(capcomp_pkg::OFS_ROUTING, {18'h00000, route}, 16'h0000);
            setw(16'h0001 << capcomp_pkg::GRP_A[g]);
            setw(16'h0001 << capcomp_pkg::GRP_B[g]);
         end
      end
      for (int k = 0; k < 200; k++) begin
         rng = xs(rng);
         route = rng[13:0];
         wr(capcomp_pkg::OFS_ROUTING, rng, 16'h0000);
         rdc(capcomp_pkg::OFS_ROUTING, {18'h00000, route});
         rng = xs(rng);
         en = rng[15:0] & capcomp_pkg::ENABLE_MASK;
         wr(capcomp_pkg::OFS_ENABLE, rng, 16'h0000);
         rdc(capcomp_pkg::OFS_ENABLE, {16'h0000, en});
         rng = xs(rng);
         setw(rng[31:16]);
         rdc(capcomp_pkg::OFS_FLAG_WORD, {16'h0000, flags});
         rng = xs(rng);
         @(posedge sys_clk);
         trapInN <= rng[0];
         // Hardware sets ride on the clear write; set wins
         flags = setFlags(clrFlags(flags, rng[15:0], ~rng[0]), rng[31:16], en);
         expL = expLines(rng[31:16], en, route);
         for (int i = 0; i < 4; i++) expCount[i] += expL[i];
         wr(capcomp_pkg::OFS_FLAG_CLEAR, {16'h0000, rng[15:0]}, rng[31:16]);
         rdc(capcomp_pkg::OFS_FLAG_WORD, {16'h0000, flags});
      end
      for (int i = 0; i < 4; i++) chk({16'h0000, count[i]}, expCount[i]);
      end_sim;
   end
endmodule
